// ### dsk_map.svh
// Constants for the skip-instruction execution block
// How it works
// - Opcode 0010 in bits 31:28 drops the 12-bit count of bytes from the packed stream.
// - A drop may start and stop at any byte lane; the rest of the word waits for the next instruction.
// - Opcode 1010 takes two words and drops count one of word zero from the luma FIFO.
// - Word one bits 11:0 and 27:16 give the byte counts dropped from the two chroma FIFOs.
// - Line start marks the first instruction of a scan line and line end the last one.
// - An early luma FIFO line end aborts the current instruction and all up to the line-end one.
// - The target address counter keeps advancing while luma bytes are being dropped.
`ifndef DSK_MAP_SVH
`define DSK_MAP_SVH
// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define DSK_OP_PACKED    4'h2
`define DSK_OP_PLANAR    4'hA
`define DSK_OP_HI        31
`define DSK_OP_LO        28
`define DSK_CNT_HI       11
`define DSK_CNT_LO       0
`define DSK_CNT3_HI      27
`define DSK_CNT3_LO      16
`define DSK_CLR_HI       23
`define DSK_CLR_LO       20
`define DSK_SET_HI       19
`define DSK_SET_LO       16
`define DSK_IRQ_BIT      24
`define DSK_EOL_BIT      26
`define DSK_SOL_BIT      27
// ----------------------------------------------------------------------
// Register offsets and bits
// ----------------------------------------------------------------------
`define DSK_REG_CTRL     12'h000
`define DSK_REG_ISTAT    12'h004
`define DSK_REG_IMASK    12'h008
`define DSK_REG_PSTAT    12'h00C
`define DSK_REG_TADDR    12'h010
`define DSK_REG_LINE     12'h014
`define DSK_IRQ_DONE     0
`define DSK_IRQ_ABORT    1
`define DSK_IRQ_BADOP    2
`define DSK_RST_ADDR     32'h0000_0000
`define DSK_RST_FLAGS    4'h0
`define DSK_WORD_BYTES   3'h4
`endif

// ### dsk_pkg.sv
// Types shared by the skip-instruction execution block
package dsk_pkg;
    // Instruction word offered by the fetch logic
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } dsk_instr_type;

    // Head of one pixel FIFO: a word is present, and it ends the line
    typedef struct packed {
        logic valid;
        logic line_end_flag;
    } dsk_head_type;

    typedef enum logic [4:0] {
        DSK_IDLE   = 5'b00001,
        DSK_WORD1  = 5'b00010,
        DSK_RUN    = 5'b00100,
        DSK_FLUSH  = 5'b01000,
        DSK_FLUSH1 = 5'b10000
    } dsk_state_type;
endpackage

// ### dsk_lane_drop.sv
// Byte-lane discard engine for one pixel FIFO
`timescale 1ns/1ps
`default_nettype none
`include "dsk_map.svh"
module dsk_lane_drop (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              start,
    input  wire logic [11:0]       count,
    input  wire logic              abort,
    input  wire dsk_pkg::dsk_head_type head,
    output logic                   pop,
    output logic                   busy,
    output logic [2:0]             take,
    output logic                   eol_pop,
    output logic                   cut_short
);
    import dsk_pkg::*;

    logic [1:0]  offset;
    logic [11:0] remain;
    logic [2:0]  room;
    logic [2:0]  sum;

    // Bytes dropped this cycle: what is left of the word or of the count
    always_comb begin
        room = `DSK_WORD_BYTES - {1'b0, offset};
        take = 3'h0;
        if (busy && head.valid) begin
            take = (remain < {9'h000, room}) ? remain[2:0] : room;
        end
        sum       = {1'b0, offset} + take;
        pop       = busy && head.valid && (sum == `DSK_WORD_BYTES);
        eol_pop   = pop && head.line_end_flag;
        cut_short = eol_pop && (remain != {9'h000, take});
    end

    // Byte offset survives between instructions, so a word may be shared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset <= 2'h0;
        end else if (pop) begin
            offset <= 2'h0;
        end else if (!abort) begin
            offset <= sum[1:0];
        end
    end

    // Remaining count; a zero count finishes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= 12'h000;
            busy   <= 1'b0;
        end else if (abort) begin
            remain <= 12'h000;
            busy   <= 1'b0;
        end else if (start) begin
            remain <= count;
            busy   <= (count != 12'h000);
        end else if (busy) begin
            remain <= remain - {9'h000, take};
            busy   <= (remain != {9'h000, take});
        end
    end

    start_load_a : assert property (@(posedge pclk) disable iff (!presetn)
        start && !abort |=> remain == $past(count))
        else $error("lane count not loaded");
    word_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
        busy && head.valid && !pop && !abort |=> offset != 2'h0)
        else $error("partial word offset lost");
    word_wrap_a : assert property (@(posedge pclk) disable iff (!presetn)
        pop |=> offset == 2'h0)
        else $error("offset not reset after pop");
endmodule
`default_nettype wire

// ### dsk_exec.sv
// Skip-instruction executor with APB registers
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dsk_map.svh"
module dsk_exec (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq,
    input  wire dsk_pkg::dsk_instr_type instr,
    output logic                        instr_ready,
    input  wire dsk_pkg::dsk_head_type  luma_fifo,
    input  wire dsk_pkg::dsk_head_type  chroma_b_fifo,
    input  wire dsk_pkg::dsk_head_type  chroma_r_fifo,
    output logic [2:0]                  fifo_pop,
    output logic [31:0]                 target_addr,
    output logic [3:0]                  program_status_flags,
    output logic                        line_active
);
    import dsk_pkg::*;

    // ------------------------------------------------------------------
    // Field decoding
    // ------------------------------------------------------------------
    function automatic logic [3:0] op_of(input logic [31:0] w);
        op_of = w[`DSK_OP_HI:`DSK_OP_LO];
    endfunction

    function automatic logic [11:0] cnt_of(input logic [31:0] w);
        cnt_of = w[`DSK_CNT_HI:`DSK_CNT_LO];
    endfunction

    dsk_state_type state;
    dsk_head_type  heads [3];
    logic [31:0]   word0;
    logic          enable;
    logic [2:0]    istat;
    logic [2:0]    imask;
    logic [2:0]    start_vec;
    logic [11:0]   counts [3];
    logic [2:0]    busy_vec;
    logic [2:0]    takes [3];
    logic [2:0]    eol_vec;
    logic [2:0]    cut_vec;
    logic          abort;
    logic          take_word;
    logic          eol_hit;
    logic          early;
    logic          finish;
    logic          wr_en;
    logic          rd_en;
    logic          hit;
    logic [2:0]    ev;

    assign heads[0] = luma_fifo;
    assign heads[1] = chroma_b_fifo;
    assign heads[2] = chroma_r_fifo;

    // ------------------------------------------------------------------
    // Discard lanes, one per pixel FIFO
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_lane
        dsk_lane_drop u_lane (
            .pclk      (pclk),
            .presetn   (presetn),
            .start     (start_vec[i]),
            .count     (counts[i]),
            .abort     (abort),
            .head      (heads[i]),
            .pop       (fifo_pop[i]),
            .busy      (busy_vec[i]),
            .take      (takes[i]),
            .eol_pop   (eol_vec[i]),
            .cut_short (cut_vec[i])
        );
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // Words are taken in idle (when enabled), for word one, and in flush
    always_comb begin
        instr_ready = ((state == DSK_IDLE) && enable) ||
                      (state == DSK_WORD1) || (state == DSK_FLUSH) ||
                      (state == DSK_FLUSH1);
        take_word   = instr_ready && instr.valid;
    end

    // Only the luma stream carries the line boundary the program follows
    always_comb begin
        early  = (state == DSK_RUN) && cut_vec[0];
        abort  = early;
        finish = (state == DSK_RUN) && !early &&
                 (busy_vec == 3'b000);
    end

    // Lane start pulses and byte counts
    always_comb begin
        start_vec = 3'b000;
        counts[0] = cnt_of(instr.data);
        counts[1] = cnt_of(instr.data);
        counts[2] = instr.data[`DSK_CNT3_HI:`DSK_CNT3_LO];
        if (take_word && (state == DSK_IDLE) &&
            (op_of(instr.data) == `DSK_OP_PACKED)) begin
            start_vec = 3'b001;
        end else if (take_word && (state == DSK_WORD1)) begin
            // Luma count comes from the stored first word
            counts[0] = cnt_of(word0);
            start_vec = 3'b111;
        end
    end

    // Instruction state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DSK_IDLE;
        end else begin
            unique case (state)
                DSK_IDLE: begin
                    if (take_word) begin
                        if (op_of(instr.data) == `DSK_OP_PACKED) begin
                            state <= DSK_RUN;
                        end else if (op_of(instr.data) == `DSK_OP_PLANAR) begin
                            state <= DSK_WORD1;
                        end
                    end
                end
                DSK_WORD1: begin
                    if (take_word) begin
                        state <= DSK_RUN;
                    end
                end
                DSK_RUN: begin
                    if (early) begin
                        // Aborted line-end instruction closes the abort
                        state <= word0[`DSK_EOL_BIT] ? DSK_IDLE
                                                     : DSK_FLUSH;
                    end else if (finish) begin
                        state <= (eol_hit && !word0[`DSK_EOL_BIT])
                                 ? DSK_FLUSH : DSK_IDLE;
                    end
                end
                DSK_FLUSH: begin
                    if (take_word) begin
                        if (op_of(instr.data) == `DSK_OP_PLANAR) begin
                            state <= DSK_FLUSH1;
                        end else if (instr.data[`DSK_EOL_BIT]) begin
                            state <= DSK_IDLE;
                        end
                    end
                end
                DSK_FLUSH1: begin
                    if (take_word) begin
                        state <= word0[`DSK_EOL_BIT] ? DSK_IDLE
                                                     : DSK_FLUSH;
                    end
                end
            endcase
        end
    end

    // First word kept for the whole instruction, also while flushing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word0 <= 32'h0000_0000;
        end else if (take_word && (state != DSK_WORD1) &&
                     (state != DSK_FLUSH1)) begin
            word0 <= instr.data;
        end
    end

    // Remembers a luma line end seen while the instruction ran
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eol_hit <= 1'b0;
        end else if (state != DSK_RUN) begin
            eol_hit <= 1'b0;
        end else if (eol_vec[0]) begin
            eol_hit <= 1'b1;
        end
    end

    // Line tracking: start flag opens a line, end flag closes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_active <= 1'b0;
        end else if (take_word && (state == DSK_IDLE) &&
                     instr.data[`DSK_SOL_BIT]) begin
            line_active <= 1'b1;
        end else if ((finish || early) && word0[`DSK_EOL_BIT]) begin
            line_active <= 1'b0;
        end else if ((state == DSK_FLUSH) && take_word &&
                     instr.data[`DSK_EOL_BIT]) begin
            line_active <= 1'b0;
        end
    end

    // Status flags change only when an instruction completes normally
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_status_flags <= `DSK_RST_FLAGS;
        end else if (finish) begin
            program_status_flags <=
                (program_status_flags & ~word0[`DSK_CLR_HI:`DSK_CLR_LO]) |
                word0[`DSK_SET_HI:`DSK_SET_LO];
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait states; unmapped offsets answer with an error
    always_comb begin
        pready = 1'b1;
        wr_en  = psel && penable && pwrite;
        rd_en  = psel && penable && !pwrite;
        hit    = (paddr == `DSK_REG_CTRL) || (paddr == `DSK_REG_ISTAT) ||
                 (paddr == `DSK_REG_IMASK) || (paddr == `DSK_REG_PSTAT) ||
                 (paddr == `DSK_REG_TADDR) || (paddr == `DSK_REG_LINE);
        pslverr = psel && penable && !hit;
    end

    // Control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'b0;
            imask  <= 3'h0;
        end else if (wr_en && (paddr == `DSK_REG_CTRL)) begin
            enable <= pwdata[0];
        end else if (wr_en && (paddr == `DSK_REG_IMASK)) begin
            imask <= pwdata[2:0];
        end
    end

    // Events: flagged completion, early line end, foreign opcode
    always_comb begin
        ev = 3'h0;
        ev[`DSK_IRQ_DONE]  = finish && word0[`DSK_IRQ_BIT];
        ev[`DSK_IRQ_ABORT] = early;
        ev[`DSK_IRQ_BADOP] = take_word && (state == DSK_IDLE) &&
                             (op_of(instr.data) != `DSK_OP_PACKED) &&
                             (op_of(instr.data) != `DSK_OP_PLANAR);
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat <= 3'h0;
        end else if (wr_en && (paddr == `DSK_REG_ISTAT)) begin
            istat <= (istat & ~pwdata[2:0]) | ev;
        end else begin
            istat <= istat | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat & imask);
        end
    end

    // Address counter: software load, else advance by dropped luma bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_addr <= `DSK_RST_ADDR;
        end else if (wr_en && (paddr == `DSK_REG_TADDR)) begin
            target_addr <= pwdata;
        end else begin
            target_addr <= target_addr + {29'h0, takes[0]};
        end
    end

    // Read data is registered in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `DSK_REG_CTRL:  prdata <= {31'h0, enable};
                `DSK_REG_ISTAT: prdata <= {29'h0, istat};
                `DSK_REG_IMASK: prdata <= {29'h0, imask};
                `DSK_REG_PSTAT: prdata <= {23'h0, state,
                                           program_status_flags};
                `DSK_REG_TADDR: prdata <= target_addr;
                `DSK_REG_LINE:  prdata <= {31'h0, line_active};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    packed_go_a : assert property (take_word && (state == DSK_IDLE) &&
        (op_of(instr.data) == `DSK_OP_PACKED) |=> state == DSK_RUN)
        else $error("packed skip not started");
    planar_word1_a : assert property (take_word && (state == DSK_IDLE) &&
        (op_of(instr.data) == `DSK_OP_PLANAR) |=> state == DSK_WORD1 ##0
        !busy_vec[0])
        else $error("planar skip did not wait for word one");
    chroma_count_a : assert property (take_word && (state == DSK_WORD1) |=>
        g_lane[0].u_lane.remain == $past(cnt_of(word0)) &&
        g_lane[2].u_lane.remain ==
        $past(instr.data[`DSK_CNT3_HI:`DSK_CNT3_LO]))
        else $error("planar counts not loaded");
    status_apply_a : assert property (finish |=> program_status_flags ==
        (($past(program_status_flags) &
        ~$past(word0[`DSK_CLR_HI:`DSK_CLR_LO])) |
        $past(word0[`DSK_SET_HI:`DSK_SET_LO])))
        else $error("status flags not applied");
    line_open_a : assert property (take_word && (state == DSK_IDLE) &&
        instr.data[`DSK_SOL_BIT] |=> line_active)
        else $error("line start not tracked");
    early_abort_a : assert property (early |=> busy_vec == 3'b000 &&
        (state == DSK_FLUSH || state == DSK_IDLE))
        else $error("early line end not aborted");
    addr_walk_a : assert property (!(wr_en && paddr == `DSK_REG_TADDR) |=>
        target_addr == $past(target_addr) + $past(takes[0]))
        else $error("target address did not advance");
    irq_level_a : assert property (istat[0] && imask[0] |=> irq)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// ### dsk_prog_model.sv
// Instruction program memory that feeds words to the skip executor
`timescale 1ns/1ps
`default_nettype none
module dsk_prog_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                instr_ready,
    output var dsk_pkg::dsk_instr_type instr
);
    import dsk_pkg::*;
    logic [31:0] mem [0:31];
    logic [4:0]  pc;
    logic [4:0]  limit;
    logic [31:0] last;

    // ------------------------------------------------------------------
    // Word offer
    // ------------------------------------------------------------------
    // Words go out exactly as the bench wrote them, reserved bits zero
    always_comb begin
        instr.valid = (pc != limit);
        // An idle fetch bus shows no stale word
        instr.data  = instr.valid ? mem[pc] : ~last;
    end

    // Advance only when the executor really takes the word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc   <= 5'h00;
            last <= 32'h0000_0000;
        end else if (instr.valid && instr_ready) begin
            pc   <= pc + 5'h01;
            last <= mem[pc];
        end
    end
endmodule
`default_nettype wire

// ### dsk_tb.sv
// Self-checking bench for the skip-instruction executor
`timescale 1ns/1ps
`default_nettype none
`include "dsk_map.svh"
module testbench;
    import dsk_pkg::*;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    dsk_instr_type instr;
    logic          instr_ready;
    dsk_head_type  luma_fifo;
    dsk_head_type  chroma_b_fifo;
    dsk_head_type  chroma_r_fifo;
    logic [2:0]    fifo_pop;
    logic [31:0]   target_addr;
    logic [3:0]    program_status_flags;
    logic          line_active;
    int            pops [3];
    int            miscompares;
    int            tests_run;
    logic [31:0]   rd;
    logic          err;

    dsk_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .instr(instr), .instr_ready(instr_ready), .luma_fifo(luma_fifo),
        .chroma_b_fifo(chroma_b_fifo), .chroma_r_fifo(chroma_r_fifo),
        .fifo_pop(fifo_pop), .target_addr(target_addr),
        .program_status_flags(program_status_flags),
        .line_active(line_active));
    dsk_prog_model u_prog (.pclk(pclk), .presetn(presetn),
        .instr_ready(instr_ready), .instr(instr));

    // ------------------------------------------------------------------
    // Clock, pop counting and helpers
    // ------------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    // Pops are single-cycle strobes, so every edge is counted
    always @(posedge pclk) begin
        for (int i = 0; i < 3; i++) pops[i] += fifo_pop[i];
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the bench never assumes a wait count
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    function automatic logic [31:0] iw(input logic [3:0] op,
        input logic line_start_flag, input logic line_end_flag, input logic irqb,
        input logic [3:0] clr, input logic [3:0] set, input logic [11:0] n);
        return {op, line_start_flag, line_end_flag, 1'b0, irqb, clr, set, 4'h0, n};
    endfunction

    // Load words behind the ones pending and wait until all are done
    task automatic run(input logic [31:0] w [$]);
        @(posedge pclk);
        foreach (w[i]) u_prog.mem[5'(u_prog.limit + i)] = w[i];
        u_prog.limit <= u_prog.limit + 5'(w.size());
        repeat (3) @(posedge pclk);
        for (int k = 0; k < 300; k++) begin
            @(negedge pclk);
            if (u_prog.pc == u_prog.limit && instr_ready === 1'b1) break;
        end
        // A program that never drains counts as a failure, not a hang
        if (u_prog.pc != u_prog.limit || instr_ready !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time,
                     {instr_ready, u_prog.pc}, {1'b1, u_prog.limit});
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, an unmapped access, then enable
    task automatic t_regs;
        apb(1'b0, `DSK_REG_TADDR, 32'h0); chk(rd, 32'h0000_0000);
        apb(1'b0, `DSK_REG_PSTAT, 32'h0); chk(rd, 32'h0000_0010);
        apb(1'b0, 12'h020, 32'h0); chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `DSK_REG_CTRL, 32'h1);
        apb(1'b1, `DSK_REG_TADDR, 32'h100);
    endtask

    // Two packed drops meeting inside one word, address keeps moving
    task automatic t_packed;
        run('{iw(`DSK_OP_PACKED, 1, 0, 0, 4'h0, 4'h3, 12'h005)});
        chk(pops[0], 1);
        chk(target_addr, 32'h105);
        chk(program_status_flags, 4'h3);
        chk(line_active, 1'b1);
        run('{iw(`DSK_OP_PACKED, 0, 1, 0, 4'h1, 4'h0, 12'h003)});
        chk(pops[0], 2);
        chk(target_addr, 32'h108);
        chk(program_status_flags, 4'h2);
        chk(line_active, 1'b0);
    endtask

    // Planar drop with interrupt, mask and clear
    task automatic t_planar;
        apb(1'b1, `DSK_REG_IMASK, 32'h1);
        run('{iw(`DSK_OP_PLANAR, 1, 1, 1, 4'hF, 4'h5, 12'h008),
              {4'h0, 12'h00C, 4'h0, 12'h004}});
        chk(pops[0], 4);
        chk(pops[1], 1);
        chk(pops[2], 3);
        chk(program_status_flags, 4'h5);
        // Interrupt is registered one cycle behind the sticky bit
        @(negedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, `DSK_REG_IMASK, 32'h0);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, `DSK_REG_IMASK, 32'h1);
        apb(1'b1, `DSK_REG_ISTAT, 32'h1);
        apb(1'b0, `DSK_REG_ISTAT, 32'h0); chk(rd, 32'h0000_0000);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
    endtask

    // Early line end aborts up to the instruction flagged as line end
    task automatic t_abort;
        @(posedge pclk);
        luma_fifo.line_end_flag <= 1'b1;
        run('{iw(`DSK_OP_PACKED, 1, 0, 0, 4'h0, 4'h8, 12'h028),
              iw(`DSK_OP_PACKED, 0, 0, 0, 4'h0, 4'h8, 12'h004),
              iw(`DSK_OP_PACKED, 0, 1, 0, 4'h0, 4'h8, 12'h004)});
        chk(pops[0], 5);
        chk(program_status_flags, 4'h5);
        chk(line_active, 1'b0);
        apb(1'b0, `DSK_REG_ISTAT, 32'h0); chk(rd, 32'h0000_0002);
        apb(1'b0, `DSK_REG_PSTAT, 32'h0); chk(rd, 32'h0000_0015);
        // A foreign opcode is consumed and flagged, the executor stays idle
        run('{iw(4'h0, 0, 0, 0, 4'h0, 4'h0, 12'h000)});
        apb(1'b0, `DSK_REG_ISTAT, 32'h0); chk(rd, 32'h0000_0006);
        apb(1'b0, `DSK_REG_PSTAT, 32'h0); chk(rd, 32'h0000_0015);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        luma_fifo = '{valid: 1'b1, line_end_flag: 1'b0};
        chroma_b_fifo = '{valid: 1'b1, line_end_flag: 1'b0};
        chroma_r_fifo = '{valid: 1'b1, line_end_flag: 1'b0};
        u_prog.limit = 5'h00;
        pops = '{0, 0, 0};
        miscompares = 0; tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_packed;
        t_planar;
        t_abort;
        complete_run;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #(25 * 20000);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire
